// ### logic/usm_pkg.sv
package usm_pkg;

  // Operating mode select value that enables the SPI master
  localparam logic [1:0] OP_MODE_SPI = 2'b11;

  // Frame shape
  localparam int FRAME_BITS = 8;
  localparam logic [3:0] EDGE_LAST = 4'h f;

  // Rate divisor width and value after reset
  localparam int DIV_W = 12;
  localparam logic [11:0] DIV_RESET = 12'h000;

  // Buffer sizes
  localparam int TX_FIFO_DEPTH = 32;
  localparam logic [1:0] RX_BUF_DEPTH = 2'h2;

  // Values after reset
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic IDLE_LINE = 1'b1;

  // Shape of a frame as software selects it
  typedef struct packed {
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic bit_order_sel;
  } usm_cfg_type;

  // Receiver error flags, unused in this mode
  typedef struct packed {
    logic frame_error_flag;
    logic overrun_flag;
    logic parity_error_flag;
  } usm_err_type;

  localparam usm_err_type ERR_NONE = 3'h0;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } usm_state_type;

endpackage

// ### logic/usm_fifo.sv
`timescale 1ns/1ns
module usm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("usm_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
      mem[wptr] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      if (push)
        wptr <= wptr + AW'(1);
      if (pop)
        rptr <= rptr + AW'(1);
      count <= next_count;
      // Registered flags keep the ports glitch free
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule // usm_fifo

// ### logic/usm_spi_master.sv
`timescale 1ns/1ns
// What this block does
// - Polarity and phase pick SPI modes 0-3
// - Change data one edge, sample the other
// - Frames are exactly eight data bits
// - One order select for both directions
// - Order select one sends LSB first
// - Next frame follows, else line idles high
// - Two writes send sixteen bits, then done
// - Receiver works only with transmitter on
// - Transmitter enable claims serial output pin
// - Receiver enable claims serial input pin
// - Clock pin shifts regardless of receiver
// - Only a data write starts a transfer
// - Buffered byte loads once shifter frees
// - Overflow drops newest byte, keeps older ones
// - Normal flags; error flags read zero
// - Done sets after last frame, cleared by one
// - SPI master only when mode bits 11
// - Clock rate is system over 2(divisor+1)
module usm_spi_master #(
  parameter int TX_DEPTH = usm_pkg::TX_FIFO_DEPTH
) (
  // Clock, reset, freeze
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Configuration
  input wire logic [1:0] op_mode_select,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic clk_pin_direction,
  input wire usm_pkg::usm_cfg_type cfg,
  input wire logic [usm_pkg::DIV_W-1:0] rate_divisor,
  // Data buffer write
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  // Data buffer read
  input wire logic rd_strobe,
  output logic [7:0] rx_data,
  // Status
  output logic tx_empty_flag,
  output logic tx_done_flag,
  input wire logic tx_done_clr,
  output logic rx_full_flag,
  output usm_pkg::usm_err_type err_flags,
  // Pins
  output logic xfer_clock_pin,
  output logic xfer_clock_oe_n,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input wire logic serial_in_pin,
  output logic serial_in_claim
);
  import usm_pkg::*;

  initial
  begin
    if (TX_DEPTH < 2)
      $error("usm_spi_master needs a transmit buffer of at least two");
  end

  usm_state_type state;
  logic spi_on;
  logic tx_on;
  logic next_tx_on;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [3:0] edge_cnt;
  logic sclk;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] next_rx_sh;
  logic sin_meta;
  logic sin_sync;
  logic sample_now;
  logic shift_now;
  logic frame_done;
  logic load;
  logic wr_accept;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] rx_buf0;
  logic [7:0] rx_buf1;
  logic [1:0] rx_count;
  logic [7:0] next_buf0;
  logic [7:0] next_buf1;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign spi_on = op_mode_select == OP_MODE_SPI;

  // only a data write feeds the shifter
  assign wr_accept = wr_valid && tx_enable && spi_on && tx_empty_flag;

  usm_fifo #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH)
  ) tx_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .in_valid(wr_accept),
    .in_ready(tx_empty_flag),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(load),
    .out_data(fifo_data)
  );

  // half period of divisor plus one cycles
  assign tick = (state == ST_SHIFT) && (div_cnt == '0);
  // sample on leading edge when phase is zero
  assign sample_now = tick && (edge_cnt[0] == cfg.clock_phase_sel);
  assign shift_now = tick && (edge_cnt[0] != cfg.clock_phase_sel) && (edge_cnt != '0);
  assign frame_done = tick && (edge_cnt == EDGE_LAST);
  assign load = tx_on && fifo_valid && ((state == ST_IDLE) || frame_done);

  // one order select for the receive path too
  always_comb
  begin
    next_rx_sh = rx_sh;
    if (sample_now)
    begin
      if (cfg.bit_order_sel)
        next_rx_sh = {sin_sync, rx_sh[7:1]};
      else
        next_rx_sh = {rx_sh[6:0], sin_sync};
    end
  end

  always_comb
  begin
    next_tx_on = tx_on;
    if (!spi_on)
      next_tx_on = 1'b0;
    else if (tx_enable)
      next_tx_on = 1'b1;
    else if (state == ST_IDLE && !fifo_valid)
      next_tx_on = 1'b0;
  end

  assign push = frame_done && rx_enable && tx_on;
  assign pop = rd_strobe && (rx_count != '0);

  // a full buffer drops the newest byte
  always_comb
  begin
    next_buf0 = rx_buf0;
    next_buf1 = rx_buf1;
    next_count = rx_count;
    if (!rx_enable || !spi_on)
      next_count = '0;
    else
    begin
      if (pop)
      begin
        next_buf0 = rx_buf1;
        next_count = rx_count - 2'h1;
      end
      if (push && next_count < RX_BUF_DEPTH)
      begin
        if (next_count == '0)
          next_buf0 = next_rx_sh;
        else
          next_buf1 = next_rx_sh;
        next_count = next_count + 2'h1;
      end
    end
  end

  // Input pin synchroniser
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sin_meta <= IDLE_LINE;
      sin_sync <= IDLE_LINE;
    end
    else if (clk_en)
    begin
      sin_meta <= serial_in_pin;
      sin_sync <= sin_meta;
    end
  end

  // Pin ownership
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_on <= 1'b0;
      serial_out_oe_n <= 1'b1;
      serial_in_claim <= 1'b0;
      xfer_clock_oe_n <= 1'b1;
      err_flags <= ERR_NONE;
    end
    else if (clk_en)
    begin
      tx_on <= next_tx_on;
      serial_out_oe_n <= !next_tx_on;
      serial_in_claim <= rx_enable && spi_on;
      // clock pin driven with or without receiver
      xfer_clock_oe_n <= !(clk_pin_direction && next_tx_on);
      err_flags <= ERR_NONE;
    end
  end

  // Frame sequencer and rate counter
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      div_cnt <= DIV_RESET;
      edge_cnt <= '0;
    end
    else if (clk_en)
    begin
      if (!spi_on)
      begin
        state <= ST_IDLE;
        div_cnt <= rate_divisor;
        edge_cnt <= '0;
      end
      else
      begin
        if (state == ST_IDLE || tick)
          div_cnt <= rate_divisor;
        else
          div_cnt <= div_cnt - DIV_W'(1);
        if (tick)
          edge_cnt <= edge_cnt + 4'h1;
        // back to back when a byte waits
        if (load)
        begin
          state <= ST_SHIFT;
          edge_cnt <= '0;
        end
        else if (frame_done)
          state <= ST_IDLE;
      end
    end
  end

  // Clock pin level, rests at polarity
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      sclk <= 1'b0;
    else if (clk_en)
    begin
      // idle level is the polarity select
      if (state == ST_IDLE || !spi_on)
        sclk <= cfg.clock_polarity_sel;
      else if (tick)
        sclk <= !sclk;
    end
  end

  assign xfer_clock_pin = sclk;

  // Transmit shifter and output line
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_sh <= DATA_RESET;
      serial_out_pin <= IDLE_LINE;
    end
    else if (clk_en)
    begin
      // Leaving the mode aborts, so the line must rest at once
      if (!spi_on)
        serial_out_pin <= IDLE_LINE;
      // order select one puts LSB first
      else if (load)
      begin
        tx_sh <= fifo_data;
        serial_out_pin <= cfg.bit_order_sel ? fifo_data[0] : fifo_data[7];
      end
      // setup on the edge opposite the sample
      else if (shift_now && !frame_done)
      begin
        if (cfg.bit_order_sel)
        begin
          tx_sh <= {1'b0, tx_sh[7:1]};
          serial_out_pin <= tx_sh[1];
        end
        else
        begin
          tx_sh <= {tx_sh[6:0], 1'b0};
          serial_out_pin <= tx_sh[6];
        end
      end
      else if (frame_done || state == ST_IDLE)
        serial_out_pin <= IDLE_LINE;
    end
  end

  // Receive shifter and buffer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_sh <= DATA_RESET;
      rx_buf0 <= DATA_RESET;
      rx_buf1 <= DATA_RESET;
      rx_count <= '0;
      rx_full_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_sh <= next_rx_sh;
      rx_buf0 <= next_buf0;
      rx_buf1 <= next_buf1;
      rx_count <= next_count;
      rx_full_flag <= next_count != '0;
    end
  end

  assign rx_data = rx_buf0;

  // Transmit done flag, set wins over clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      tx_done_flag <= 1'b0;
    else if (clk_en)
    begin
      // set only when nothing is pending
      if (frame_done && !fifo_valid && !wr_accept)
        tx_done_flag <= 1'b1;
      else if (tx_done_clr)
        tx_done_flag <= 1'b0;
    end
  end

  default clocking dcb @(posedge sys_clk iff clk_en);
  endclocking
  default disable iff (!arst_n);

  sequence frame_end_s;
    frame_done && !fifo_valid && !wr_accept;
  endsequence

  sequence load_s;
    load && spi_on;
  endsequence

  idle_line_high_a: assert property ((state == ST_IDLE) |-> serial_out_pin)
    else $error("data line not high while idle");
  first_bit_order_a: assert property (load_s |=>
    serial_out_pin == $past(cfg.bit_order_sel ? fifo_data[0] : fifo_data[7]))
    else $error("first bit does not follow order select");
  done_sets_a: assert property (frame_end_s |=> tx_done_flag)
    else $error("transmit done did not set");
  done_waits_a: assert property (frame_done && fifo_valid |=> !$rose(tx_done_flag))
    else $error("transmit done set with byte pending");
  mode_gate_a: assert property (!spi_on |=> state == ST_IDLE && !tx_on)
    else $error("shifter active outside SPI mode");
  start_by_write_a: assert property ($rose(state == ST_SHIFT) |-> $past(load))
    else $error("frame started without a buffered write");
  rx_needs_tx_a: assert property ($rose(rx_full_flag) |-> $past(tx_on))
    else $error("receive without transmitter");
  rx_flush_a: assert property (!rx_enable |=> !rx_full_flag)
    else $error("receive buffer not flushed");
  overflow_keep_a: assert property (rx_count == RX_BUF_DEPTH && !rd_strobe && rx_enable
    && spi_on |=> $stable(rx_data))
    else $error("older received byte lost on overflow");
  errors_zero_a: assert property (err_flags == ERR_NONE)
    else $error("error flag raised");
  half_period_a: assert property (tick && spi_on |=> div_cnt == $past(rate_divisor))
    else $error("rate counter reload wrong");
  clock_idle_a: assert property (state == ST_IDLE && spi_on |=>
    xfer_clock_pin == $past(cfg.clock_polarity_sel))
    else $error("clock pin not resting at polarity");
  tx_claim_a: assert property (tx_on |-> !serial_out_oe_n)
    else $error("output pin not claimed");
  tx_empty_reset_a: assert property ($fell(tx_empty_flag) |-> $past(wr_accept))
    else $error("transmit empty fell without a write");
endmodule // usm_spi_master

// ### sim/usm_spi_slave.sv
`timescale 1ns/1ns
module usm_spi_slave (
  // Bus pins
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // Frame shape and restart
  input wire usm_pkg::usm_cfg_type cfg,
  input wire logic sync,
  // Observed traffic
  output logic [7:0] last_rx,
  output int frames
);
  import usm_pkg::*;
  logic [7:0] shift_in;
  logic [7:0] reply;
  int idx;
  logic mosi_held;
  // Hold time: data launched on the sample edge must not be seen there
  always @(mosi)
    mosi_held <= #1 mosi;
  // Distinct reply per frame, so a lost byte shows
  assign reply = 8'h00a0 + frames[7:0];
  assign miso = cfg.bit_order_sel ? reply[idx] : reply[7 - idx];
  always @(sclk or posedge sync)
  begin
    if (sync)
    begin
      idx = 0;
      frames = 0;
    end
    else if (sclk === ~(cfg.clock_polarity_sel ^ cfg.clock_phase_sel))
    begin
      shift_in[cfg.bit_order_sel ? idx : 7 - idx] = mosi_held;
      idx = idx + 1;
      if (idx == 8)
      begin
        last_rx = shift_in;
        frames = frames + 1;
        idx = 0;
      end
    end
  end
endmodule // usm_spi_slave

// ### sim/tb_usart_spi_master.sv
`timescale 1ns/1ns
module tb_usart_spi_master;
  import usm_pkg::*;
  logic sys_clk = 0, arst_n = 0, clk_en = 1, tx_enable = 0, rx_enable = 0;
  logic [1:0] op_mode_select = 2'b00;
  logic clk_pin_direction = 0, wr_valid = 0, rd_strobe = 0, tx_done_clr = 0, sync = 0;
  usm_cfg_type cfg = 3'h0;
  logic [DIV_W-1:0] rate_divisor = 12'h000;
  logic [7:0] wr_data = 8'h00, rx_data, last_rx;
  logic tx_empty_flag, tx_done_flag, rx_full_flag, xfer_clock_pin, xfer_clock_oe_n;
  logic serial_out_pin, serial_out_oe_n, miso, serial_in_claim;
  usm_err_type err_flags;
  int frames, miscompares = 0, check_count = 0, cycles = 0, acc, m;
  always #20 sys_clk = ~sys_clk;
  usm_spi_master #(.TX_DEPTH(TX_FIFO_DEPTH)) DUT (.sys_clk(sys_clk), .arst_n(arst_n),
    .clk_en(clk_en), .op_mode_select(op_mode_select), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .clk_pin_direction(clk_pin_direction), .cfg(cfg),
    .rate_divisor(rate_divisor), .wr_valid(wr_valid), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .rx_data(rx_data), .tx_empty_flag(tx_empty_flag),
    .tx_done_flag(tx_done_flag), .tx_done_clr(tx_done_clr), .rx_full_flag(rx_full_flag),
    .err_flags(err_flags), .xfer_clock_pin(xfer_clock_pin),
    .xfer_clock_oe_n(xfer_clock_oe_n), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n), .serial_in_pin(miso),
    .serial_in_claim(serial_in_claim));
  usm_spi_slave slave (.sclk(xfer_clock_pin), .mosi(serial_out_pin), .miso(miso),
    .cfg(cfg), .sync(sync), .last_rx(last_rx), .frames(frames));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs always move 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic pulse_sync;
    sync = 1;
    tick(1);
    sync = 0;
  endtask
  task automatic clear_done;
    tx_done_clr = 1;
    tick(1);
    tx_done_clr = 0;
    tick(1);
  endtask
  // Valid held high across the burst; counts bytes taken
  task automatic burst(input logic [7:0] base, input int n, output int taken);
    taken = 0;
    for (int i = 0; i < n; i++)
    begin
      wr_valid = 1;
      wr_data = base + i[7:0];
      taken += int'(tx_empty_flag);
      tick(1);
    end
    wr_valid = 0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (tx_done_flag !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    chk_bit(tx_done_flag, 1'b1);
  endtask
  task automatic read_chk(input logic [7:0] exp);
    chk_byte(rx_data, exp);
    rd_strobe = 1;
    tick(1);
    rd_strobe = 0;
    tick(1);
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    // Whole run needs about 3400 cycles
    if (cycles == 12000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    tick(6);
    arst_n = 1;
    chk_bit(tx_empty_flag, 1'b1);
    chk_bit(tx_done_flag, 1'b0);
    chk_bit(serial_out_pin, 1'b1);
    chk_bit(serial_out_oe_n, 1'b1);
    op_mode_select = OP_MODE_SPI;
    clk_pin_direction = 1;
    tx_enable = 1;
    rx_enable = 1;
    tick(2);
    rate_divisor = 12'h003;
    tick(2);
    chk_bit(serial_out_oe_n, 1'b0);
    chk_bit(xfer_clock_oe_n, 1'b0);
    chk_bit(serial_in_claim, 1'b1);
    for (m = 0; m < 8; m++)
    begin
      cfg = m[2:0];
      tick(4);
      pulse_sync();
      clear_done();
      burst(8'h003a + m[7:0], 1, acc);
      wait_done();
      chk_byte(last_rx, 8'h003a + m[7:0]);
      chk_bit(serial_out_pin, 1'b1);
      chk_bit(xfer_clock_pin, cfg.clock_polarity_sel);
      read_chk(8'h00a0);
    end
    pulse_sync();
    clear_done();
    burst(8'h0050, 3, acc);
    tick(80);
    chk_bit(tx_done_flag, 1'b0);
    wait_done();
    chk_byte(frames[7:0], 8'h0003);
    chk_byte(last_rx, 8'h0052);
    read_chk(8'h00a0);
    read_chk(8'h00a1);
    chk_bit(rx_full_flag, 1'b0);
    pulse_sync();
    clear_done();
    burst(8'h0000, 40, acc);
    chk_bit(acc == TX_FIFO_DEPTH || acc == TX_FIFO_DEPTH + 1, 1'b1);
    chk_bit(tx_empty_flag, 1'b0);
    wait_done();
    chk_byte(frames[7:0], acc[7:0]);
    chk_byte(last_rx, acc[7:0] - 8'h0001);
    chk_bit(tx_empty_flag, 1'b1);
    chk_bit(rx_full_flag, 1'b1);
    rx_enable = 0;
    tick(2);
    chk_bit(rx_full_flag, 1'b0);
    chk_bit(serial_in_claim, 1'b0);
    pulse_sync();
    clear_done();
    burst(8'h00c5, 2, acc);
    tx_enable = 0;
    tick(4);
    chk_bit(serial_out_oe_n, 1'b0);
    wait_done();
    chk_byte(last_rx, 8'h00c6);
    tick(2);
    chk_bit(serial_out_oe_n, 1'b1);
    chk_bit(rx_full_flag, 1'b0);
    tx_enable = 1;
    op_mode_select = 2'b01;
    tick(4);
    pulse_sync();
    burst(8'h0077, 1, acc);
    tick(200);
    chk_byte(frames[7:0], 8'h0000);
    op_mode_select = OP_MODE_SPI;
    tick(4);
    pulse_sync();
    clear_done();
    burst(8'h00e1, 1, acc);
    wait_done();
    chk_byte(last_rx, 8'h00e1);
    chk_byte({5'h00, err_flags}, 8'h0000);
    report_and_stop();
  end
endmodule // tb_usart_spi_master
